// ==== core/dts_ctrl.v ====
// dual tag snoop coherency controller with apb status/interrupt registers
// assumes one clock; processor and system bus inputs synchronous to it
`timescale 1ns/1ns
`include "dts_defines.vh"
// Summary of operation
// - write-through completes when memory write finishes
// - buffered write loads cache and post buffer
// - controller drains posted write over system bus
// - processor write hit sets dirty flag in copy-back mode
// - flush dirty lines before granting bus
// - external read of dirty entry written back first
// - write to absent address is write miss
// - watch system bus for foreign writes
// - processor page compare gives hit or miss
// - snoop compare runs parallel to processor compare
// - snoop miss leaves both tags alone
// - snoop write hit invalidates entry or all entries
// - both tag copies written identically, same cycle
// - lookup takes a single tag access time
// - active-low clear invalidates whole tag
// - hit needs valid flag set
module dts_ctrl #(
	parameter IDX_W  = 4,
	parameter PAGE_W = 8,
	parameter DATA_W = 32
) (
	// clock, reset, clear and strap
	input  wire                    i_clk,
	input  wire                    i_resetn,
	input  wire                    i_clear_n,
	input  wire [1:0]              i_policy,
	// processor side
	input  wire                    i_cpu_req,
	input  wire                    i_cpu_we,
	input  wire [IDX_W+PAGE_W-1:0] i_cpu_addr,
	input  wire [DATA_W-1:0]       i_cpu_wdata,
	output wire                    o_cpu_hit,
	output wire                    o_cpu_ready,
	output reg                     o_cache_we,
	output reg  [IDX_W-1:0]        o_cache_idx,
	output reg  [DATA_W-1:0]       o_cache_wdata,
	// memory write port on the system bus
	output reg                     o_mem_req,
	output reg  [IDX_W+PAGE_W-1:0] o_mem_addr,
	output reg  [DATA_W-1:0]       o_mem_wdata,
	output reg                     o_mem_wb,
	input  wire                    i_mem_done,
	input  wire [DATA_W-1:0]       i_cache_rdata,
	// system bus snooping and arbitration
	input  wire                    i_sys_start,
	input  wire                    i_sys_we,
	input  wire                    i_sys_foreign,
	input  wire [IDX_W+PAGE_W-1:0] i_sys_addr,
	input  wire                    i_bus_req,
	output wire                    o_bus_grant,
	output wire                    o_sys_hold,
	// apb
	input  wire                    psel,
	input  wire                    penable,
	input  wire                    pwrite,
	input  wire [11:0]             paddr,
	input  wire [31:0]             pwdata,
	output reg  [31:0]             prdata,
	output wire                    pready,
	output wire                    pslverr,
	// interrupt
	output wire                    o_irq
);
	localparam DEPTH  = 1 << IDX_W;
	localparam S_IDLE = 6'b000001;
	localparam S_WT   = 6'b000010;
	localparam S_DRN  = 6'b000100;
	localparam S_FLSH = 6'b001000;
	localparam S_GRNT = 6'b010000;
	localparam S_SWB  = 6'b100000;

	// ==========================================================
	// address split and tag lookups
	wire [IDX_W-1:0]  cpu_idx  = i_cpu_addr[IDX_W-1:0];
	wire [PAGE_W-1:0] cpu_page = i_cpu_addr[IDX_W+PAGE_W-1:IDX_W];
	wire [IDX_W-1:0]  sys_idx  = i_sys_addr[IDX_W-1:0];
	wire [PAGE_W-1:0] sys_page = i_sys_addr[IDX_W+PAGE_W-1:IDX_W];
	wire              cpu_dirty;
	wire [PAGE_W-1:0] cpu_lk_page;
	wire              snp_hit;
	wire              snp_dirty;
	reg               tw;
	reg  [IDX_W-1:0]  tw_idx;
	reg  [PAGE_W-1:0] tw_page;
	reg               tw_valid;
	reg               tw_dirty;
	reg               all_inv;
	reg  [5:0]        state_r;
	reg  [5:0]        state_nxt;
	reg  [1:0]        pol_r;
	reg               pol_taken_r;
	reg  [IDX_W-1:0]  scan_r;
	reg  [31:0]       ctrl_r;
	reg  [3:0]        ist_r;
	reg  [3:0]        ien_r;
	wire              clr_all_n = i_clear_n && !all_inv && !ctrl_r[`DTS_CTRL_FLUSH];

	// both copies share the update port so they never differ
	dts_tag_mem #(.IDX_W(IDX_W), .PAGE_W(PAGE_W)) u_cpu_tag (
		.i_clk      (i_clk),
		.i_resetn   (i_resetn),
		.i_lk_idx   ((state_r == S_FLSH) ? scan_r : cpu_idx),
		.i_lk_page  (cpu_page),
		.o_lk_hit   (o_cpu_hit),
		.o_lk_dirty (cpu_dirty),
		.o_lk_page  (cpu_lk_page),
		.i_clear_n  (clr_all_n),
		.i_wr       (tw),
		.i_wr_idx   (tw_idx),
		.i_wr_page  (tw_page),
		.i_wr_valid (tw_valid),
		.i_wr_dirty (tw_dirty)
	);
	// snoop copy compares the system address in the same cycle
	dts_tag_mem #(.IDX_W(IDX_W), .PAGE_W(PAGE_W)) u_snp_tag (
		.i_clk      (i_clk),
		.i_resetn   (i_resetn),
		.i_lk_idx   (sys_idx),
		.i_lk_page  (sys_page),
		.o_lk_hit   (snp_hit),
		.o_lk_dirty (snp_dirty),
		.o_lk_page  (),
		.i_clear_n  (clr_all_n),
		.i_wr       (tw),
		.i_wr_idx   (tw_idx),
		.i_wr_page  (tw_page),
		.i_wr_valid (tw_valid),
		.i_wr_dirty (tw_dirty)
	);

	// ==========================================================
	// write policy strap
	always @(posedge i_clk) begin
		if (!i_resetn) begin
			pol_r       <= `DTS_POL_WT;
			pol_taken_r <= 1'b0;
		end else if (!pol_taken_r) begin
			pol_r       <= i_policy;
			pol_taken_r <= 1'b1;
		end
	end

	// ==========================================================
	// event decode
	wire is_cb     = (pol_r == `DTS_POL_CB);
	wire is_bwt    = (pol_r == `DTS_POL_BWT);
	wire snoop_ev  = i_sys_start && i_sys_foreign;
	wire snp_wr_hit = snoop_ev && i_sys_we && snp_hit;
	wire snp_rd_dirty = snoop_ev && !i_sys_we && snp_hit && snp_dirty && is_cb;
	wire cpu_wr    = i_cpu_req && i_cpu_we && state_r == S_IDLE;
	wire wmiss     = cpu_wr && !o_cpu_hit;
	wire cpu_wr_ok = cpu_wr && !snp_wr_hit && !snp_rd_dirty;
	wire flush_req = is_cb && i_bus_req && state_r == S_IDLE && !i_cpu_req;
	reg  wb_ev;

	// a dirty entry not yet being written back
	function o_cpu_hit_dummy_dirty;
		input d;
		input busy;
		o_cpu_hit_dummy_dirty = d && !busy;
	endfunction

	// ==========================================================
	// controller state machine
	always @* begin
		state_nxt = state_r;
		case (state_r)
			S_IDLE: begin
				if (snp_rd_dirty)
					state_nxt = S_SWB;
				else if (cpu_wr_ok && !is_cb)
					state_nxt = is_bwt ? S_DRN : S_WT;
				else if (flush_req)
					state_nxt = S_FLSH;
			end
			S_WT:    if (i_mem_done) state_nxt = S_IDLE;
			S_DRN:   if (i_mem_done) state_nxt = S_IDLE;
			S_SWB:   if (i_mem_done) state_nxt = S_IDLE;
			S_FLSH: begin
				if (!o_mem_req && scan_r == DEPTH - 1 && !(cpu_dirty && !o_mem_wb))
					state_nxt = S_GRNT;
			end
			S_GRNT:  if (!i_bus_req) state_nxt = S_IDLE;
			default: state_nxt = S_IDLE;
		endcase
	end

	// tag update port: one writer for both copies
	always @* begin
		tw       = 1'b0;
		tw_idx   = cpu_idx;
		tw_page  = cpu_page;
		tw_valid = 1'b1;
		tw_dirty = 1'b0;
		all_inv  = 1'b0;
		if (snp_wr_hit) begin
			if (ctrl_r[`DTS_CTRL_ALLINV])
				all_inv = 1'b1;
			else begin
				tw       = 1'b1;
				tw_idx   = sys_idx;
				tw_page  = sys_page;
				tw_valid = 1'b0;
			end
		end else if (state_r == S_FLSH && i_mem_done) begin
			tw       = 1'b1;
			tw_idx   = scan_r;
			tw_page  = o_mem_addr[IDX_W+PAGE_W-1:IDX_W];
		end else if (state_r == S_SWB && i_mem_done) begin
			tw       = 1'b1;
			tw_idx   = o_mem_addr[IDX_W-1:0];
			tw_page  = o_mem_addr[IDX_W+PAGE_W-1:IDX_W];
		end else if (cpu_wr_ok) begin
			tw       = 1'b1;
			tw_dirty = is_cb;
		end
	end

	// processor stalls for write-through memory cycles, copy-back work and a write issued while a posted write drains
	assign o_cpu_ready = (state_r == S_IDLE && !(i_cpu_we && !cpu_wr_ok)
	                      && !(i_cpu_we && !is_cb && !is_bwt))
	                   || (state_r == S_WT && i_mem_done)
	                   || (state_r == S_DRN && !i_cpu_we);
	assign o_bus_grant = (state_r == S_GRNT) || (!is_cb && state_r == S_IDLE && i_bus_req);
	assign o_sys_hold  = (state_r == S_SWB);

	always @(posedge i_clk) begin
		if (!i_resetn) begin
			state_r       <= S_IDLE;
			scan_r        <= {IDX_W{1'b0}};
			o_mem_req     <= 1'b0;
			o_mem_wb      <= 1'b0;
			o_mem_addr    <= {(IDX_W+PAGE_W){1'b0}};
			o_mem_wdata   <= {DATA_W{1'b0}};
			o_cache_we    <= 1'b0;
			o_cache_idx   <= {IDX_W{1'b0}};
			o_cache_wdata <= {DATA_W{1'b0}};
			wb_ev         <= 1'b0;
		end else begin
			state_r    <= state_nxt;
			o_cache_we <= 1'b0;
			wb_ev      <= 1'b0;
			if (i_mem_done) begin
				o_mem_req <= 1'b0;
				o_mem_wb  <= 1'b0;
				wb_ev     <= o_mem_wb;
			end
			if (state_r == S_IDLE && cpu_wr_ok) begin
				o_cache_we    <= 1'b1;
				o_cache_idx   <= cpu_idx;
				o_cache_wdata <= i_cpu_wdata;
				if (!is_cb) begin
					o_mem_req   <= 1'b1;
					o_mem_addr  <= i_cpu_addr;
					o_mem_wdata <= i_cpu_wdata; // posted buffer in buffered mode
				end
			end
			if (state_r == S_IDLE && snp_rd_dirty) begin
				o_mem_req   <= 1'b1;
				o_mem_wb    <= 1'b1;
				o_mem_addr  <= i_sys_addr;
				o_mem_wdata <= i_cache_rdata;
			end
			if (state_r == S_IDLE && flush_req)
				scan_r <= {IDX_W{1'b0}};
			// flush walk: one entry per step, write back when dirty
			if (state_r == S_FLSH && !o_mem_req) begin
				if (o_cpu_hit_dummy_dirty(cpu_dirty, o_mem_wb)) begin
					o_mem_req   <= 1'b1;
					o_mem_wb    <= 1'b1;
					o_mem_addr  <= {cpu_lk_page, scan_r};
					o_mem_wdata <= i_cache_rdata;
				end else if (scan_r != DEPTH - 1)
					scan_r <= scan_r + 1'b1;
			end
		end
	end

	// ==========================================================
	// apb registers and interrupt
	wire apb_wr = psel && penable && pwrite;
	assign pready  = 1'b1;
	assign pslverr = 1'b0;
	wire [3:0] ev_set = {o_cache_we && !is_cb && !is_bwt, wb_ev, wmiss, snp_wr_hit};
	always @(posedge i_clk) begin
		if (!i_resetn) begin
			ctrl_r <= `DTS_ZERO32;
			ist_r  <= 4'h0;
			ien_r  <= 4'h0;
		end else begin
			ctrl_r[`DTS_CTRL_FLUSH] <= 1'b0;
			if (apb_wr && paddr == `DTS_REG_CTRL)
				ctrl_r <= pwdata;
			if (apb_wr && paddr == `DTS_REG_IRQ_EN)
				ien_r <= pwdata[3:0];
			// set wins over a clear in the same cycle
			ist_r <= (ist_r & ~((apb_wr && paddr == `DTS_REG_IRQ_CLR) ? pwdata[3:0] : 4'h0))
			       | ev_set;
		end
	end
	assign o_irq = |(ist_r & ien_r);
	always @* begin
		case (paddr)
			`DTS_REG_CTRL:   prdata = ctrl_r;
			`DTS_REG_STAT:   prdata = {24'h000000, pol_r, state_r};
			`DTS_REG_IRQ_ST: prdata = {28'h0000000, ist_r};
			`DTS_REG_IRQ_EN: prdata = {28'h0000000, ien_r};
			default:         prdata = `DTS_ZERO32;
		endcase
	end
endmodule

// ==== core/dts_defines.vh ====
// constants for the dual tag snoop coherency controller
// included by the core files; definitions only
`ifndef DTS_DEFINES_VH
`define DTS_DEFINES_VH
// write policy encodings
`define DTS_POL_WT      2'h0
`define DTS_POL_BWT     2'h1
`define DTS_POL_CB      2'h2
// apb register offsets
`define DTS_REG_CTRL    12'h000
`define DTS_REG_STAT    12'h004
`define DTS_REG_IRQ_ST  12'h008
`define DTS_REG_IRQ_EN  12'h00C
`define DTS_REG_IRQ_CLR 12'h010
// ctrl fields
`define DTS_CTRL_FLUSH  0
`define DTS_CTRL_ALLINV 1
// interrupt event bits
`define DTS_EV_SNOOP    0
`define DTS_EV_WMISS    1
`define DTS_EV_WBACK    2
`define DTS_EV_W        3
`define DTS_ZERO32      32'h00000000
`endif

// ==== core/dts_tag_mem.v ====
// one tag copy: page, valid and dirty per entry, with a single-cycle compare
// assumes writes come from the controller which drives both copies alike
`timescale 1ns/1ns
`include "dts_defines.vh"
module dts_tag_mem #(
	parameter IDX_W  = 4,
	parameter PAGE_W = 8
) (
	// clock and reset
	input  wire              i_clk,
	input  wire              i_resetn,
	// lookup port
	input  wire [IDX_W-1:0]  i_lk_idx,
	input  wire [PAGE_W-1:0] i_lk_page,
	output wire              o_lk_hit,
	output wire              o_lk_dirty,
	output wire [PAGE_W-1:0] o_lk_page,
	// update port
	input  wire              i_clear_n,
	input  wire              i_wr,
	input  wire [IDX_W-1:0]  i_wr_idx,
	input  wire [PAGE_W-1:0] i_wr_page,
	input  wire              i_wr_valid,
	input  wire              i_wr_dirty
);
	localparam DEPTH = 1 << IDX_W;
	reg [PAGE_W-1:0] page_r  [0:DEPTH-1];
	reg [DEPTH-1:0]  valid_r;
	reg [DEPTH-1:0]  dirty_r;
	genvar g;
	// hit needs both page equality and the valid flag
	assign o_lk_hit   = valid_r[i_lk_idx] && (page_r[i_lk_idx] == i_lk_page);
	assign o_lk_dirty = dirty_r[i_lk_idx];
	// stored page lets a write-back rebuild the full line address
	assign o_lk_page  = page_r[i_lk_idx];
	generate
		for (g = 0; g < DEPTH; g = g + 1) begin : g_ent
			always @(posedge i_clk) begin
				if (!i_resetn || !i_clear_n) begin
					valid_r[g] <= 1'b0;
					dirty_r[g] <= 1'b0;
				end else if (i_wr && i_wr_idx == g) begin
					valid_r[g] <= i_wr_valid;
					dirty_r[g] <= i_wr_dirty;
				end
			end
			always @(posedge i_clk) begin
				if (i_wr && i_wr_idx == g)
					page_r[g] <= i_wr_page;
			end
		end
	endgenerate
endmodule

// ==== verification/dts_ctrl_asserts.sv ====
// checker: coherency timing seen at the controller ports
// assumes one clock and a policy strap that only moves in reset
`timescale 1ns/1ns
`include "dts_defines.vh"
module dts_chk #(
	parameter IDX_W  = 4,
	parameter PAGE_W = 8,
	parameter DATA_W = 32,
	parameter AW     = IDX_W + PAGE_W
) (
	// clock, reset, strap
	input wire              i_clk,
	input wire              i_resetn,
	input wire              i_clear_n,
	input wire [1:0]        i_policy,
	// processor side
	input wire              i_cpu_req,
	input wire              i_cpu_we,
	input wire [AW-1:0]     i_cpu_addr,
	input wire [DATA_W-1:0] i_cpu_wdata,
	input wire              o_cpu_hit,
	input wire              o_cpu_ready,
	input wire              o_cache_we,
	input wire [DATA_W-1:0] o_cache_wdata,
	// system bus
	input wire              o_mem_req,
	input wire [AW-1:0]     o_mem_addr,
	input wire              o_mem_wb,
	input wire              i_mem_done,
	input wire              i_sys_start,
	input wire              i_sys_we,
	input wire              i_sys_foreign,
	input wire [AW-1:0]     i_sys_addr,
	input wire              o_bus_grant,
	input wire              o_sys_hold
);
	default clocking @(posedge i_clk);
	endclocking
	default disable iff (!i_resetn);
	// a foreign transfer while the processor idles on a hitting address
	wire wr_ok = i_cpu_req && i_cpu_we && o_cpu_ready;
	wire snp   = i_sys_start && i_sys_foreign && o_cpu_hit && !i_cpu_req;

	a_wt_wait: assert property (wr_ok && i_policy == `DTS_POL_WT |-> i_mem_done)
		else $error("wt write ended before memory");
	a_bwt_post: assert property (wr_ok && i_policy == `DTS_POL_BWT |-> ##[1:2] o_mem_req)
		else $error("posted write not drained");
	a_cache_data: assert property (o_cache_we |-> o_cache_wdata == $past(i_cpu_wdata))
		else $error("cache data wrong");
	a_mem_hold: assert property (o_mem_req && !i_mem_done |=> o_mem_req && $stable(o_mem_addr))
		else $error("memory request dropped");
	a_grant_clean: assert property (o_bus_grant && i_policy == `DTS_POL_CB |-> !o_mem_req)
		else $error("grant during write-back");
	a_hold_wb: assert property ($rose(o_sys_hold) |-> ##[0:1] (o_mem_req && o_mem_wb))
		else $error("hold without write-back");
	a_snoop_inv: assert property (snp && i_sys_we && i_sys_addr == i_cpu_addr
		|=> !o_cpu_hit || $changed(i_cpu_addr)) else $error("snoop hit kept entry");
	a_snoop_miss: assert property (snp && i_sys_addr != i_cpu_addr && i_clear_n
		|=> o_cpu_hit || $changed(i_cpu_addr)) else $error("snoop miss changed tag");
	a_read_keep: assert property (snp && !i_sys_we && i_policy != `DTS_POL_CB
		|=> o_cpu_hit || $changed(i_cpu_addr)) else $error("read invalidated");
	a_clear_all: assert property (!i_clear_n |=> !o_cpu_hit)
		else $error("clear left a hit");
	c_hold: cover property (o_sys_hold);
	c_grant: cover property (o_bus_grant);
	c_snoop: cover property (snp && i_sys_we);
endmodule

bind dts_ctrl dts_chk #(.IDX_W(IDX_W), .PAGE_W(PAGE_W), .DATA_W(DATA_W)) u_chk (
	.i_clk, .i_resetn, .i_clear_n, .i_policy, .i_cpu_req, .i_cpu_we, .i_cpu_addr,
	.i_cpu_wdata, .o_cpu_hit, .o_cpu_ready, .o_cache_we, .o_cache_wdata, .o_mem_req,
	.o_mem_addr, .o_mem_wb, .i_mem_done, .i_sys_start, .i_sys_we, .i_sys_foreign,
	.i_sys_addr, .o_bus_grant, .o_sys_hold);

// ==== verification/dts_ctrl_tb.sv ====
// testbench: drives the controller under each write policy
// assumes the memory partner and the bound checker
`timescale 1ns/1ns
`include "dts_defines.vh"
module dts_ctrl_tb;
	localparam [11:0] A = 12'h123, B = 12'hEDC;
	logic        i_clk = 0, i_resetn = 0, i_clear_n = 1, i_cpu_req = 0, i_cpu_we = 0;
	logic        i_sys_start = 0, i_sys_we = 0, i_sys_foreign = 0, i_bus_req = 0;
	logic        psel = 0, penable = 0, pwrite = 0, slow = 0, h;
	logic [1:0]  i_policy = 0;
	logic [11:0] i_cpu_addr = 0, i_sys_addr = 0, paddr = 0;
	logic [31:0] i_cpu_wdata = 0, pwdata = 0, rd, lf = 65;
	wire  [31:0] prdata, cache_rd, mem_wdata, cache_wdata;
	wire  [11:0] mem_addr;
	wire  [3:0]  cache_idx;
	wire         hit, ready, cache_we, mem_req, mem_wb, done, grant, hold, pready, irq;
	int          mismatches = 0, compares = 0, n, hs = 0;
	logic [43:0] exp_q [$];

	dts_ctrl u_dut (.i_clk, .i_resetn, .i_clear_n, .i_policy, .i_cpu_req, .i_cpu_we,
		.i_cpu_addr, .i_cpu_wdata, .o_cpu_hit(hit), .o_cpu_ready(ready),
		.o_cache_we(cache_we), .o_cache_idx(cache_idx), .o_cache_wdata(cache_wdata),
		.o_mem_req(mem_req), .o_mem_addr(mem_addr), .o_mem_wdata(mem_wdata),
		.o_mem_wb(mem_wb), .i_mem_done(done), .i_cache_rdata(cache_rd), .i_sys_start,
		.i_sys_we, .i_sys_foreign, .i_sys_addr, .i_bus_req, .o_bus_grant(grant),
		.o_sys_hold(hold), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr(), .o_irq(irq));
	dts_mem_model u_mem (.i_clk, .i_slow(slow), .i_req(mem_req), .o_done(done),
		.i_we(cache_we), .i_idx(cache_idx), .i_wdata(cache_wdata), .o_rdata(cache_rd));

	initial forever #50 i_clk = ~i_clk;
	// ====
	// tasks
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task chk(input logic [43:0] got, input logic [43:0] exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task wrap_up;
		$display("compares=%0d mismatches=%0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task rst(input logic [1:0] p);
		i_resetn <= 0;
		i_policy <= p;
		repeat (12) @(posedge i_clk);
		i_resetn <= 1;
		repeat (2) @(posedge i_clk);
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge i_clk) penable <= 1;
		do @(posedge i_clk); while (pready !== 1'b1);
		rd = prdata;
		psel <= 0;
		penable <= 0;
		@(posedge i_clk);
	endtask
	task cpu(input logic w, input logic [11:0] a, input logic push);
		lf = lfsr(lf);
		if (push)
			exp_q.push_back({a, lf});
		i_cpu_req <= 1;
		i_cpu_we <= w;
		i_cpu_addr <= a;
		i_cpu_wdata <= lf;
		n = 0;
		do begin @(posedge i_clk); n++; end while (ready !== 1'b1);
		h = hit;
		i_cpu_req <= 0;
		@(posedge i_clk);
	endtask
	task sys(input logic w, input logic f, input logic [11:0] a);
		i_sys_start <= 1;
		i_sys_we <= w;
		i_sys_foreign <= f;
		i_sys_addr <= a;
		@(posedge i_clk) i_sys_start <= 0;
		n = 0;
		do begin @(posedge i_clk); n++; end while ((hold || mem_req) && n < 50);
	endtask
	// ====
	// memory write reference and watchdog
	always @(posedge i_clk) begin
		hs <= hs + hold;
		if (mem_req && done)
			chk({mem_addr, mem_wdata}, exp_q.size() ? exp_q.pop_front() : 'x);
	end
	initial begin
		#200000;
		mismatches++;
		wrap_up;
	end
	// ====
	// main sequence
	initial begin
		rst(`DTS_POL_WT);
		apb(0, 12'h020, 0);
		chk(rd, 0);
		cpu(0, B, 0); chk(h, 0);
		cpu(1, A, 1); chk(exp_q.size(), 0);
		chk(irq, 0);
		apb(0, `DTS_REG_IRQ_ST, 0); chk(rd[3:0] & 4'hB, 4'hA);
		apb(1, `DTS_REG_IRQ_EN, 32'hF); chk(irq, 1);
		apb(1, `DTS_REG_IRQ_CLR, 32'hF); chk(irq, 0);
		cpu(0, A, 0); chk(h, 1);
		sys(0, 1, A);
		sys(1, 1, B);
		sys(1, 0, A);
		cpu(0, A, 0); chk(h, 1);
		sys(1, 1, A);
		cpu(0, A, 0); chk(h, 0);
		cpu(1, A, 1);
		i_clear_n <= 0;
		@(posedge i_clk) i_clear_n <= 1;
		cpu(0, A, 0); chk(h, 0);
		rst(`DTS_POL_BWT);
		slow <= 1;
		cpu(1, A, 1); chk(n < 3, 1);
		cpu(0, A, 0); chk({h, 1'(exp_q.size())}, 2'b11);
		sys(0, 0, B);
		chk(exp_q.size(), 0);
		rst(`DTS_POL_CB);
		slow <= 0;
		cpu(1, A, 0);
		exp_q.push_back({A, lf});
		sys(0, 1, A); chk({hs != 0, 1'(exp_q.size())}, 2'b10);
		cpu(1, A, 1);
		i_bus_req <= 1;
		n = 0;
		do begin @(posedge i_clk); n++; end while (!grant && n < 50);
		chk({grant, 1'(exp_q.size())}, 2'b10);
		i_bus_req <= 0;
		repeat (2) @(posedge i_clk);
		wrap_up;
	end
endmodule

// ==== verification/dts_mem_model.sv ====
// partner: main memory write port and the cache data array
// assumes requests stay up until the done pulse
`timescale 1ns/1ns
module dts_mem_model (
	// clock and pace
	input  wire        i_clk,
	input  wire        i_slow,
	// memory write port
	input  wire        i_req,
	output logic       o_done,
	// data array
	input  wire        i_we,
	input  wire [3:0]  i_idx,
	input  wire [31:0] i_wdata,
	output wire [31:0] o_rdata
);
	logic [31:0] arr [16];
	int          cnt = 0;
	assign o_rdata = arr[i_idx];
	initial o_done = 1'b0;
	always @(posedge i_clk) begin
		if (i_we)
			arr[i_idx] <= i_wdata;
		o_done <= 1'b0;
		cnt <= 0;
		// slow mode keeps a posted write in flight long enough to see it
		if (i_req && !o_done) begin
			cnt <= cnt + 1;
			if (cnt >= (i_slow ? 6 : 1))
				o_done <= 1'b1;
		end
	end
endmodule
